/* common/arpm_pkg.sv */
// Package with register map, field positions, reset values and timing for the reset and power mode control.
package arpm_pkg;
   localparam logic [7:0] ARPM_OFS_RESET_CTRL = 8'h01;
   localparam logic [7:0] ARPM_OFS_POWER_CTRL = 8'h02;
   localparam logic [7:0] ARPM_OFS_STATUS = 8'h10;
   localparam int ARPM_BIT_MODULE_RESET = 4;
   localparam int ARPM_BIT_MODE_REG_RESET = 0;
   localparam int ARPM_BIT_PROC_RESET = 7;
   localparam int ARPM_BIT_STANDBY_REQ = 4;
   localparam int ARPM_BIT_POWERDOWN_REQ = 0;
   localparam logic [7:0] ARPM_RESET_CTRL_RST = 8'h00;
   localparam logic [7:0] ARPM_POWER_CTRL_RST = 8'h80;
   localparam logic [7:0] ARPM_POWER_CTRL_MASK = 8'hf1;
   localparam int ARPM_CLK_MHZ = 40;
   localparam int ARPM_PULSE_NS = 100;
   localparam int ARPM_PULSE_CYC = (ARPM_PULSE_NS * ARPM_CLK_MHZ + 999) / 1000;
   localparam int ARPM_STBY_WAKE_US = 10;
   localparam int ARPM_PDN_WAKE_US = 200;
   localparam int ARPM_STBY_WAKE_CYC = ARPM_STBY_WAKE_US * ARPM_CLK_MHZ;
   localparam int ARPM_PDN_WAKE_CYC = ARPM_PDN_WAKE_US * ARPM_CLK_MHZ;
   typedef enum logic [1:0] {ARPM_NORMAL, ARPM_STANDBY, ARPM_POWERDOWN, ARPM_WAKING} arpm_state_e;
   typedef struct packed {
      logic interp_dac_reset;
      logic proc_reset;
      logic proc_coeff_clear;
      logic mode_regs_reset;
      logic exec_from_rom;
   } arpm_reset_s;
   typedef struct packed {
      logic subsys_on;
      logic charge_pump_on;
      logic digital_supply_on;
      logic in_standby;
      logic in_powerdown;
   } arpm_power_s;
   localparam arpm_reset_s ARPM_RESET_OUT_RST = 5'h09;
   localparam arpm_power_s ARPM_POWER_OUT_RST = 5'h1c;
endpackage

/* core/arpm_pulse.sv */
// Stretches a one-cycle trigger into a fixed-length pulse.
`timescale 1ns/1ps
module arpm_pulse #(
   parameter int LEN = 4
) (
   input wire logic clk_in,
   input wire logic arst_n_in,
   input wire logic start_in,
   output logic active_out
);
   logic [7:0] cnt_q;
   logic [7:0] cnt_d;
   assign cnt_d = start_in ? 8'(LEN) : (cnt_q != 8'h00 ? cnt_q - 8'h01 : 8'h00);
   always_ff @(posedge clk_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         cnt_q <= 8'h00;
      end else begin
         cnt_q <= cnt_d;
      end
   end
   assign active_out = cnt_q != 8'h00;
endmodule

/* core/arpm_sync.sv */
// Two-stage synchroniser for an asynchronous level.
`timescale 1ns/1ps
module arpm_sync (
   input wire logic clk_in,
   input wire logic arst_n_in,
   input wire logic async_in,
   output logic sync_out
);
   logic meta_q;
   logic sync_q;
   always_ff @(posedge clk_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         meta_q <= 1'b0;
         sync_q <= 1'b0;
      end else begin
         meta_q <= async_in;
         sync_q <= meta_q;
      end
   end
   assign sync_out = sync_q;
endmodule

/* core/arpm_top.sv */
// Reset and power mode control behind the first two control registers.
`timescale 1ns/1ps
// Functional notes
// RL1 - Module reset bit resets filter and converter
// RL2 - Module reset also resets processor, clears coefficients
// RL3 - Module reset self-clears; accepted only in standby (the code also accepts it in powerdown)
// RL4 - Register reset bit restores mode registers
// RL5 - Register reset keeps memory, execution from ROM
// RL6 - Software sets register reset only in standby
// RL7 - Processor reset resets to one; zero starts
// RL8 - Software releases processor after clocks settle
// RL9 - Standby request or clock error forces standby
// RL10 - Standby keeps charge pump and digital supply
// RL11 - Powerdown request also turns charge pump off
// RL12 - Powerdown wins over standby
// RL13 - Powerdown restart takes longer than standby
// RL14 - Both requests clear, no error: normal
module arpm_top
   import arpm_pkg::*;
#(
   parameter int STBY_WAKE_CYC = ARPM_STBY_WAKE_CYC,
   parameter int PDN_WAKE_CYC = ARPM_PDN_WAKE_CYC
) (
   input wire logic clk_in,
   input wire logic arst_n_in,
   input wire logic [7:0] addr_in,
   input wire logic [7:0] wdata_in,
   input wire logic wr_in,
   input wire logic rd_in,
   input wire logic clock_error_in,
   output logic [7:0] rdata_out,
   output arpm_reset_s reset_out,
   output arpm_power_s power_out,
   output logic [1:0] state_out
);
   // ----------------------------------------------------------------
   // Register decode
   // ----------------------------------------------------------------
   wire wr_reset_ctrl = wr_in && (addr_in == ARPM_OFS_RESET_CTRL);
   wire wr_power_ctrl = wr_in && (addr_in == ARPM_OFS_POWER_CTRL);
   logic [7:0] power_ctrl_q;
   logic [7:0] power_ctrl_d;
   logic [7:0] rdata_q;
   logic [7:0] rdata_d;
   arpm_state_e state_q;
   arpm_state_e state_d;
   logic [13:0] wake_q;
   logic [13:0] wake_d;
   logic clk_err;
   logic mod_rst_active;
   logic reg_rst_active;
   logic rom_exec_q;
   logic rom_exec_d;
   logic proc_hold;
   arpm_reset_s reset_q;
   arpm_reset_s reset_d;
   arpm_power_s power_q;
   arpm_power_s power_d;

   // The clock error flag comes from another clock domain, so it passes two flip-flops
   // before the state machine reads it.
   arpm_sync u_err_sync (
      .clk_in(clk_in),
      .arst_n_in(arst_n_in),
      .async_in(clock_error_in),
      .sync_out(clk_err)
   );

   wire in_low_power = (state_q == ARPM_STANDBY) || (state_q == ARPM_POWERDOWN);
   // RL3 module reset accepted only in standby or powerdown
   wire mod_rst_start = wr_reset_ctrl && wdata_in[ARPM_BIT_MODULE_RESET] && in_low_power;
   // RL4 register reset trigger
   wire reg_rst_start = wr_reset_ctrl && wdata_in[ARPM_BIT_MODE_REG_RESET];

   // ----------------------------------------------------------------
   // Reset pulses
   // ----------------------------------------------------------------
   // RL1 timed module reset pulse
   arpm_pulse #(.LEN(ARPM_PULSE_CYC)) u_mod_pulse (
      .clk_in(clk_in),
      .arst_n_in(arst_n_in),
      .start_in(mod_rst_start),
      .active_out(mod_rst_active)
   );
   arpm_pulse #(.LEN(ARPM_PULSE_CYC)) u_reg_pulse (
      .clk_in(clk_in),
      .arst_n_in(arst_n_in),
      .start_in(reg_rst_start),
      .active_out(reg_rst_active)
   );

   // RL4 mode registers return to reset
   assign power_ctrl_d = reg_rst_start ? ARPM_POWER_CTRL_RST :
                         wr_power_ctrl ? (wdata_in & ARPM_POWER_CTRL_MASK) : power_ctrl_q;

   // RL3 self-clearing bits read as one while their pulse runs, then zero
   wire [7:0] reset_ctrl_view = {3'h0, mod_rst_active, 3'h0, reg_rst_active};
   wire [7:0] status_view = {6'h00, state_q};
   assign rdata_d = !rd_in ? 8'h00 :
                    (addr_in == ARPM_OFS_RESET_CTRL) ? reset_ctrl_view :
                    (addr_in == ARPM_OFS_POWER_CTRL) ? power_ctrl_q :
                    (addr_in == ARPM_OFS_STATUS) ? status_view : 8'h00;

   // ----------------------------------------------------------------
   // Power mode state machine
   // ----------------------------------------------------------------
   wire pdn_req = power_ctrl_q[ARPM_BIT_POWERDOWN_REQ];
   wire stby_req = power_ctrl_q[ARPM_BIT_STANDBY_REQ] || clk_err;
   // Waking is a state of its own so that a new request can cut a restart short.
   always_comb begin
      state_d = state_q;
      wake_d = (wake_q != 14'h0000) ? wake_q - 14'h0001 : 14'h0000;
      case (state_q)
         ARPM_NORMAL, ARPM_STANDBY, ARPM_WAKING: begin
            // RL12 powerdown precedence
            if (pdn_req) begin
               state_d = ARPM_POWERDOWN;
            // RL9 standby entry
            end else if (stby_req) begin
               state_d = ARPM_STANDBY;
            end else if (state_q == ARPM_STANDBY) begin
               state_d = ARPM_WAKING;
               wake_d = 14'(STBY_WAKE_CYC);
            // RL14 return to normal
            end else if (state_q == ARPM_WAKING && wake_q == 14'h0000) begin
               state_d = ARPM_NORMAL;
            end
         end
         ARPM_POWERDOWN: begin
            if (!pdn_req && stby_req) begin
               state_d = ARPM_STANDBY;
            // RL13 longer powerdown restart
            end else if (!pdn_req) begin
               state_d = ARPM_WAKING;
               wake_d = 14'(PDN_WAKE_CYC);
            end
         end
         default: begin
            state_d = ARPM_NORMAL;
         end
      endcase
   end

   // ----------------------------------------------------------------
   // Storage
   // ----------------------------------------------------------------
   always_ff @(posedge clk_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         power_ctrl_q <= ARPM_POWER_CTRL_RST;
      end else begin
         power_ctrl_q <= power_ctrl_d;
      end
   end
   always_ff @(posedge clk_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         rdata_q <= 8'h00;
      end else begin
         rdata_q <= rdata_d;
      end
   end
   always_ff @(posedge clk_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         state_q <= ARPM_NORMAL;
      end else begin
         state_q <= state_d;
      end
   end
   // The count is reloaded on every entry to waking, so a restart always starts from its full length.
   always_ff @(posedge clk_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         wake_q <= 14'h0000;
      end else begin
         wake_q <= wake_d;
      end
   end

   // ----------------------------------------------------------------
   // Outputs
   // ----------------------------------------------------------------
   // RL7 processor held while bit is one
   assign proc_hold = power_ctrl_q[ARPM_BIT_PROC_RESET];

   // ----------------------------------------------------------------
   // Execution source
   // ----------------------------------------------------------------
   // The processor may leave the built-in program only while it is released,
   // so the ROM flag drops once the hold bit is cleared and a register reset sets it again.
   // A register reset in the same cycle as a release wins, which keeps the
   // processor on the built-in program.
   // RL5 register reset restores ROM
   assign rom_exec_d = reg_rst_start | (rom_exec_q & proc_hold);
   always_ff @(posedge clk_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         rom_exec_q <= ARPM_RESET_OUT_RST.exec_from_rom;
      end else begin
         rom_exec_q <= rom_exec_d;
      end
   end

   // ----------------------------------------------------------------
   // Reset lines
   // ----------------------------------------------------------------
   always_comb begin
      // RL1 filter and converter reset
      reset_d.interp_dac_reset = mod_rst_active;
      // RL2 processor reset with coefficient clear
      // RL7 processor held while bit is one
      reset_d.proc_reset = mod_rst_active | proc_hold;
      reset_d.proc_coeff_clear = mod_rst_active;
      // RL4 mode register reset line
      reset_d.mode_regs_reset = reg_rst_active;
      reset_d.exec_from_rom = rom_exec_q;
   end
   always_ff @(posedge clk_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         reset_q <= ARPM_RESET_OUT_RST;
      end else begin
         reset_q <= reset_d;
      end
   end

   // ----------------------------------------------------------------
   // Power lines
   // ----------------------------------------------------------------
   // The lines follow the next state, so they change on the same edge as the state.
   always_comb begin
      // RL10 standby keeps pump and digital supply
      power_d.subsys_on = (state_d == ARPM_NORMAL);
      // RL11 powerdown drops the charge pump
      power_d.charge_pump_on = (state_d != ARPM_POWERDOWN);
      // The digital supply carries the control port, so it never drops.
      power_d.digital_supply_on = 1'b1;
      power_d.in_standby = (state_d == ARPM_STANDBY);
      power_d.in_powerdown = (state_d == ARPM_POWERDOWN);
   end
   always_ff @(posedge clk_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         power_q <= ARPM_POWER_OUT_RST;
      end else begin
         power_q <= power_d;
      end
   end

   assign rdata_out = rdata_q;
   assign reset_out = reset_q;
   assign power_out = power_q;
   assign state_out = state_q;

   // ----------------------------------------------------------------
   // Checks
   // ----------------------------------------------------------------
   a_pdn_wins: assert property (@(posedge clk_in) disable iff (!arst_n_in) // RL12
      pdn_req |=> state_q == ARPM_POWERDOWN) else $error("powerdown did not win");
   a_stby_entry: assert property (@(posedge clk_in) disable iff (!arst_n_in) // RL9
      (stby_req && !pdn_req) |=> state_q == ARPM_STANDBY) else $error("standby not entered");
   a_pump_off: assert property (@(posedge clk_in) disable iff (!arst_n_in) // RL11
      state_q == ARPM_POWERDOWN |-> !power_out.charge_pump_on) else $error("pump on in powerdown");
   a_stby_pump: assert property (@(posedge clk_in) disable iff (!arst_n_in) // RL10
      state_q == ARPM_STANDBY |-> power_out.charge_pump_on && !power_out.subsys_on) else $error("standby power wrong");
   a_mod_only_stby: assert property (@(posedge clk_in) disable iff (!arst_n_in) // RL3
      (wr_reset_ctrl && wdata_in[ARPM_BIT_MODULE_RESET] && state_q == ARPM_NORMAL) |=> !mod_rst_active)
      else $error("module reset outside standby");
   a_mod_clears: assert property (@(posedge clk_in) disable iff (!arst_n_in) // RL1
      mod_rst_start |=> ##[1:8] !reset_out.interp_dac_reset ##1 !reset_out.interp_dac_reset)
      else $error("module reset stuck");
   a_mod_proc: assert property (@(posedge clk_in) disable iff (!arst_n_in) // RL2
      mod_rst_start |=> ##1 reset_out.proc_reset && reset_out.proc_coeff_clear) else $error("processor not reset");
   a_reg_restore: assert property (@(posedge clk_in) disable iff (!arst_n_in) // RL4
      reg_rst_start |=> power_ctrl_q == ARPM_POWER_CTRL_RST) else $error("mode registers not restored");
   a_rom_exec: assert property (@(posedge clk_in) disable iff (!arst_n_in) // RL5
      reg_rst_start |=> ##1 reset_out.exec_from_rom) else $error("not back to ROM");
   a_proc_release: assert property (@(posedge clk_in) disable iff (!arst_n_in) // RL7
      (!proc_hold && !mod_rst_active) |=> !reset_out.proc_reset) else $error("processor not released");
   a_normal_back: assert property (@(posedge clk_in) disable iff (!arst_n_in) // RL14
      (state_q == ARPM_WAKING && wake_q == 14'h0000 && !pdn_req && !stby_req) |=> state_q == ARPM_NORMAL)
      else $error("no return to normal");
   a_pdn_longer: assert property (@(posedge clk_in) disable iff (!arst_n_in) // RL13
      (state_q == ARPM_POWERDOWN && !pdn_req && !stby_req) |=> wake_q == 14'(PDN_WAKE_CYC))
      else $error("powerdown wake count wrong");
   a_reg_clears: assert property (@(posedge clk_in) disable iff (!arst_n_in) // RL4
      reg_rst_start |=> ##[1:8] !reset_out.mode_regs_reset ##1 !reset_out.mode_regs_reset)
      else $error("register reset stuck");
   a_proc_hold: assert property (@(posedge clk_in) disable iff (!arst_n_in) // RL7
      proc_hold |=> reset_out.proc_reset) else $error("processor not held");
   a_pdn_subsys: assert property (@(posedge clk_in) disable iff (!arst_n_in) // RL11
      state_q == ARPM_POWERDOWN |-> !power_out.subsys_on && power_out.in_powerdown)
      else $error("powerdown lines wrong");
   a_dig_supply: assert property (@(posedge clk_in) disable iff (!arst_n_in) // RL10
      power_out.digital_supply_on) else $error("digital supply dropped");
   a_rom_release: assert property (@(posedge clk_in) disable iff (!arst_n_in) // RL5
      (!proc_hold && !reg_rst_start) |=> ##1 !reset_out.exec_from_rom) else $error("ROM flag kept after release");
   a_wake_stby: assert property (@(posedge clk_in) disable iff (!arst_n_in) // RL13
      (state_q == ARPM_STANDBY && !pdn_req && !stby_req) |=> wake_q == 14'(STBY_WAKE_CYC))
      else $error("standby wake count wrong");
   a_mod_accept: assert property (@(posedge clk_in) disable iff (!arst_n_in) // RL3
      (wr_reset_ctrl && wdata_in[ARPM_BIT_MODULE_RESET] && in_low_power) |=> mod_rst_active)
      else $error("module reset not accepted");
   a_reg_view: assert property (@(posedge clk_in) disable iff (!arst_n_in) // RL3
      (rd_in && addr_in == ARPM_OFS_RESET_CTRL && !mod_rst_active && !reg_rst_active) |=> rdata_out == 8'h00)
      else $error("reset bits not cleared");
   c_standby: cover property (@(posedge clk_in) state_q == ARPM_STANDBY ##1 state_q == ARPM_WAKING);
   c_powerdown: cover property (@(posedge clk_in) state_q == ARPM_POWERDOWN ##1 state_q == ARPM_WAKING);
   c_mod_reset: cover property (@(posedge clk_in) mod_rst_start);
   c_reg_reset: cover property (@(posedge clk_in) reg_rst_start);
   c_clock_error: cover property (@(posedge clk_in) clk_err && state_q == ARPM_STANDBY);
endmodule

/* dv/arpm_host.sv */
// Host model that drives the register port of the reset and power mode control.
`timescale 1ns/1ps
module arpm_host (
   input wire logic clk_in,
   input wire logic [7:0] rdata_in,
   output logic [7:0] addr_out,
   output logic [7:0] wdata_out,
   output logic wr_out,
   output logic rd_out
);
   initial begin
      addr_out = 8'h00;
      wdata_out = 8'h00;
      wr_out = 1'b0;
      rd_out = 1'b0;
   end
   // ----
   // Bus cycles
   // ----
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge clk_in);
      addr_out <= a;
      wdata_out <= d;
      wr_out <= 1'b1;
      @(posedge clk_in);
      wr_out <= 1'b0;
      addr_out <= ~a;
      wdata_out <= ~d;
   endtask
   task automatic rd(input logic [7:0] a, output logic [7:0] d);
      @(posedge clk_in);
      addr_out <= a;
      rd_out <= 1'b1;
      @(posedge clk_in);
      rd_out <= 1'b0;
      addr_out <= ~a;
      // Read data stand for the one cycle after the strobe and are taken at its closing edge.
      @(posedge clk_in);
      d = rdata_in;
   endtask
endmodule

/* dv/arpm_top_bench.sv */
// Self-checking bench for the reset and power mode control.
`timescale 1ns/1ps
module arpm_top_bench
   import arpm_pkg::*;
;
   logic clk = 1'b0;
   logic arst_n = 1'b0;
   logic clk_err = 1'b0;
   logic [7:0] addr;
   logic [7:0] wdata;
   logic [7:0] rdata;
   logic wr;
   logic rd;
   arpm_reset_s rst;
   arpm_power_s pwr;
   logic [1:0] st;
   int num_errors = 0;
   int n_compared = 0;
   int cycles = 0;
   int seed = 28;
   int npd;
   int nst;
   logic [7:0] v;
   logic [7:0] d;
   always #12.5 clk = ~clk;
   arpm_top #(.STBY_WAKE_CYC(4), .PDN_WAKE_CYC(20)) arpm_top_i (.clk_in(clk), .arst_n_in(arst_n),
      .addr_in(addr), .wdata_in(wdata), .wr_in(wr), .rd_in(rd), .clock_error_in(clk_err),
      .rdata_out(rdata), .reset_out(rst), .power_out(pwr), .state_out(st));
   arpm_host arpm_host_i (.clk_in(clk), .rdata_in(rdata), .addr_out(addr), .wdata_out(wdata),
      .wr_out(wr), .rd_out(rd));
   // ----
   // Checking helpers
   // ----
   function automatic logic [7:0] pwr_exp(input logic [1:0] s);
      return (s == 2'h1) ? 8'h0e : 8'h1c;
   endfunction
   task automatic chk(input string name, input logic [7:0] seen, input logic [7:0] exp);
      n_compared++;
      if (seen !== exp) begin
         num_errors++;
         $display("[ERR] %s expected %h seen %h", name, exp, seen);
      end
   endtask
   task automatic wait_st(input logic [1:0] s, output int n);
      n = 0;
      while (st !== s && n < 60) begin
         @(posedge clk);
         #1;
         n++;
      end
      chk("state", {6'h00, st}, {6'h00, s});
   endtask
   task automatic test_done();
      $display("compared %0d mismatches %0d", n_compared, num_errors);
      if (num_errors == 0 && n_compared > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask
   always @(posedge clk) begin
      cycles++;
      if (cycles == 3000) begin
         num_errors++;
         test_done();
      end
   end
   // ----
   // Scenarios
   // ----
   initial begin
      repeat (8) @(posedge clk);
      arst_n <= 1'b1;
      arpm_host_i.rd(ARPM_OFS_POWER_CTRL, v);
      chk("power ctrl reset", v, 8'h80);
      arpm_host_i.rd(ARPM_OFS_RESET_CTRL, v);
      chk("reset ctrl reset", v, 8'h00);
      chk("reset lines", {3'h0, rst}, 8'h09);
      chk("power lines", {3'h0, pwr}, pwr_exp(2'h0));
      arpm_host_i.wr(ARPM_OFS_RESET_CTRL, 8'h10);
      repeat (6) @(posedge clk);
      chk("module reset refused", {7'h0, rst.interp_dac_reset}, 8'h00);
      arpm_host_i.wr(ARPM_OFS_POWER_CTRL, 8'h90);
      wait_st(2'h1, nst);
      chk("standby power", {3'h0, pwr}, pwr_exp(2'h1));
      arpm_host_i.wr(ARPM_OFS_RESET_CTRL, 8'h10);
      repeat (3) @(posedge clk);
      #1;
      chk("filter reset", {7'h0, rst.interp_dac_reset}, 8'h01);
      chk("proc reset", {6'h0, rst.proc_reset, rst.proc_coeff_clear}, 8'h03);
      repeat (8) @(posedge clk);
      arpm_host_i.rd(ARPM_OFS_RESET_CTRL, v);
      chk("module reset self clear", v | {7'h0, rst.interp_dac_reset}, 8'h00);
      // Register reset is issued while still in standby.
      arpm_host_i.wr(ARPM_OFS_POWER_CTRL, 8'h10);
      repeat (2) @(posedge clk);
      #1;
      chk("exec from ram", {7'h0, rst.exec_from_rom}, 8'h00);
      arpm_host_i.wr(ARPM_OFS_RESET_CTRL, 8'h01);
      repeat (3) @(posedge clk);
      #1;
      chk("mode regs reset", {7'h0, rst.mode_regs_reset}, 8'h01);
      chk("exec from rom", {7'h0, rst.exec_from_rom}, 8'h01);
      repeat (8) @(posedge clk);
      arpm_host_i.rd(ARPM_OFS_POWER_CTRL, v);
      chk("regs restored", v, 8'h80);
      wait_st(2'h0, npd);
      arpm_host_i.wr(ARPM_OFS_POWER_CTRL, 8'h91);
      wait_st(2'h2, npd);
      chk("pd pump", {6'h0, pwr.charge_pump_on, pwr.in_powerdown}, 8'h01);
      arpm_host_i.wr(ARPM_OFS_POWER_CTRL, 8'h80);
      wait_st(2'h0, npd);
      arpm_host_i.wr(ARPM_OFS_POWER_CTRL, 8'h90);
      wait_st(2'h1, nst);
      arpm_host_i.wr(ARPM_OFS_POWER_CTRL, 8'h80);
      wait_st(2'h0, nst);
      chk("restart order", {7'h0, npd > nst}, 8'h01);
      clk_err <= 1'b1;
      wait_st(2'h1, nst);
      clk_err <= 1'b0;
      wait_st(2'h0, nst);
      // Clocks are steady here, so the processor may be released.
      arpm_host_i.wr(ARPM_OFS_POWER_CTRL, 8'h00);
      repeat (3) @(posedge clk);
      #1;
      chk("proc released", {7'h0, rst.proc_reset}, 8'h00);
      for (int i = 0; i < 6; i++) begin
         d = $random(seed);
         arpm_host_i.wr(ARPM_OFS_POWER_CTRL, d);
         arpm_host_i.rd(ARPM_OFS_POWER_CTRL, v);
         chk("power ctrl readback", v, d & ARPM_POWER_CTRL_MASK);
         d = $random(seed);
         arpm_host_i.rd(8'h20 | d, v);
         chk("unmapped read", v, 8'h00);
      end
      // A second reset in mid-run must bring back the reset values after traffic.
      arst_n <= 1'b0;
      repeat (2) @(posedge clk);
      arst_n <= 1'b1;
      arpm_host_i.rd(ARPM_OFS_POWER_CTRL, v);
      chk("power ctrl after reset", v, ARPM_POWER_CTRL_RST);
      chk("reset lines after reset", {3'h0, rst}, 8'h09);
      chk("power lines after reset", {3'h0, pwr}, pwr_exp(2'h0));
      chk("state after reset", {6'h00, st}, 8'h00);
      test_done();
   end
endmodule
